// *** include/gsrm_pkg.sv ***
// constants for the gpio special role mux with led driver
// Contract
// - smallest priority number wins per pin
// - pin0: programming, crystal, else input only
// - matrix/pull-up-off settings independent of priority
// - reference enable routes pin3 to counter
// - debug transaction takes pin4 as data
// - clock out on pin4/pin6 by select
// - pin5 debug clock unless led on; code gates it off for the whole led role
// - led role forces output, status reported
// - three led current levels, max 1mA
// - port0 bit5 switches led current
// - pin5 open drain for led use
// - led on disables pin5 pull-down
// - pin5 plain open drain during debug
// - config 0 open drain, 1 push-pull; code ignores config on pin5, always open drain
package gsrm_pkg;
  localparam int unsigned PIN_COUNT      = 10;          // pins of the larger package
  localparam int unsigned PIN_XTAL       = 0;           // programming / crystal pin
  localparam int unsigned PIN_REF        = 3;           // reference clock pin
  localparam int unsigned PIN_DBG_DATA   = 4;           // debug data / clock out pin
  localparam int unsigned PIN_LED        = 5;           // debug clock / led pin
  localparam int unsigned PIN_CLK_ALT    = 6;           // second clock out pin
  localparam int unsigned SEL_PIN4       = 0;           // select bit for pin 4
  localparam int unsigned SEL_PIN6       = 1;           // select bit for pin 6
  localparam logic [1:0]  LED_LEVEL_OFF  = 2'h0;        // no current selected
  localparam logic        CFG_OPEN_DRAIN = 1'h0;        // drive config value: open drain
  localparam logic        CFG_PUSH_PULL  = 1'h1;        // drive config value: push-pull
  localparam logic [7:0]  P0_RESET       = 8'hdf;       // port zero data reset
  localparam logic [7:0]  P1_RESET       = 8'h03;       // port one data reset
  localparam logic [7:0]  CON_RESET      = 8'h00;       // drive config reset
endpackage

// *** src/gsrm_pin_cell.sv ***
// one ordinary port pin driver: data plus open-drain/push-pull config
`timescale 1ns/100ps
module gsrm_pin_cell
  import gsrm_pkg::*;
(
  // data and config
  input  wire logic data,
  input  wire logic push_pull,
  // pad controls
  output logic      pad_out,
  output logic      pad_oe
);
  // open drain drives only lows; push-pull drives both levels
  assign pad_out = data;
  assign pad_oe  = (push_pull == CFG_PUSH_PULL) ? 1'b1 : ~data;
endmodule // gsrm_pin_cell

// *** src/gsrm_mux.sv ***
// pin role mux for the ten pin port with led current driver
`timescale 1ns/100ps
module gsrm_mux
  import gsrm_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // port data and drive config written by the core
  input  wire logic [7:0] port_zero_data,
  input  wire logic [7:0] port_zero_drive_config,
  input  wire logic [7:0] port_one_data,
  input  wire logic [7:0] port_one_drive_config,
  // special mode controls
  input  wire logic       programming_active,
  input  wire logic       crystal_input_enable,
  input  wire logic       reference_clock_enable,
  input  wire logic       clock_output_enable,
  input  wire logic [1:0] clock_output_pin_select,
  input  wire logic [1:0] led_current_level,
  input  wire logic       user_clock,
  // debug link state
  input  wire logic       debug_transaction,
  input  wire logic       debug_session,
  input  wire logic       debug_led_disable,
  input  wire logic       debug_link_data_out,
  input  wire logic       debug_link_data_oe,
  // pad inputs
  input  wire logic [9:0] pad_in,
  // pad outputs
  output logic [9:0]      pad_out,
  output logic [9:0]      pad_oe,
  output logic            pin5_pulldown_off,
  output logic [1:0]      led_current_sel,
  // routed special inputs
  output logic            crystal_oscillator_in,
  output logic            reference_clock_in,
  output logic            debug_link_clock,
  output logic            debug_link_data_in,
  // status
  output logic [7:0]      port_zero_read,
  output logic [7:0]      port_one_read,
  output logic            led_actual_drive_state
);
  logic [9:0] gp_out;                      // plain port value per pin
  logic [9:0] gp_oe;                       // plain port enable per pin
  logic [9:0] gp_data;                     // port data gathered per pin
  logic [9:0] gp_cfg;                      // drive config gathered per pin
  logic [9:0] out_d, out_q;                // final pad values
  logic [9:0] oe_d,  oe_q;                 // final pad enables
  logic       led_role;                    // led current selected and not in debug
  logic       led_on;                      // current actually flowing
  logic       clk4, clk6;                  // clock-out roles active
  logic       pd_off_q, drive_q, xo_q, ref_q, dclk_q, ddat_q;
  logic [1:0] lvl_q;
  logic [7:0] rd0_q, rd1_q;

  assign gp_data = {port_one_data[1:0], port_zero_data};
  assign gp_cfg  = {port_one_drive_config[1:0], port_zero_drive_config};

  // ordinary drivers, one per pin; pins 7..9 never leave this path
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      gsrm_pin_cell u_cell (
        .data      (gp_data[g]),
        .push_pull (gp_cfg[g]),
        .pad_out   (gp_out[g]),
        .pad_oe    (gp_oe[g])
      );
    end
  endgenerate

  // led role: a nonzero level and no debug session; debug falls back to open drain
  assign led_role = (led_current_level != LED_LEVEL_OFF) && !debug_session;
  assign led_on   = led_role && port_zero_data[PIN_LED] && !debug_led_disable;
  assign clk4     = clock_output_enable && clock_output_pin_select[SEL_PIN4];
  assign clk6     = clock_output_enable && clock_output_pin_select[SEL_PIN6];

  // role priority per pin, lowest order number first
  always_comb begin
    out_d = gp_out;
    oe_d  = gp_oe;
    // pin 0: never an output, whatever is written to its bit
    out_d[PIN_XTAL] = 1'b1;
    oe_d[PIN_XTAL]  = 1'b0;
    // pin 3: reference clock input overrides the port
    if (reference_clock_enable) begin
      oe_d[PIN_REF] = 1'b0;
    end
    // pin 4: debug data beats clock out beats port
    if (debug_transaction) begin
      out_d[PIN_DBG_DATA] = debug_link_data_out;
      oe_d[PIN_DBG_DATA]  = debug_link_data_oe;
    end else if (clk4) begin
      out_d[PIN_DBG_DATA] = user_clock;
      oe_d[PIN_DBG_DATA]  = 1'b1;
    end
    // pin 5: led role is open drain, output forced; pull-down off while lit
    if (led_role) begin
      out_d[PIN_LED] = 1'b0;
      oe_d[PIN_LED]  = !led_on;
    end else begin
      out_d[PIN_LED] = 1'b0;
      oe_d[PIN_LED]  = !port_zero_data[PIN_LED];
    end
    // pin 6: clock out beats port
    if (clk6) begin
      out_d[PIN_CLK_ALT] = user_clock;
      oe_d[PIN_CLK_ALT]  = 1'b1;
    end
  end

  // registered outputs; matrix and pull-up-off live in pads, untouched here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_q    <= 10'h3ff;
      oe_q     <= 10'h000;
      pd_off_q <= 1'b0;
      lvl_q    <= LED_LEVEL_OFF;
      drive_q  <= 1'b0;
      xo_q     <= 1'b0;
      ref_q    <= 1'b0;
      dclk_q   <= 1'b0;
      ddat_q   <= 1'b0;
      rd0_q    <= 8'h00;
      rd1_q    <= 8'h00;
    end else begin
      out_q    <= out_d;
      oe_q     <= oe_d;
      pd_off_q <= led_on;
      lvl_q    <= led_role ? led_current_level : LED_LEVEL_OFF;
      drive_q  <= led_on;
      // programming voltage outranks the crystal
      xo_q     <= !programming_active && crystal_input_enable
                  && pad_in[PIN_XTAL];
      ref_q    <= reference_clock_enable && pad_in[PIN_REF];
      // debug clock reads the pin whenever the led role is off
      dclk_q   <= !led_role && pad_in[PIN_LED];
      ddat_q   <= pad_in[PIN_DBG_DATA];
      // pin 5 reads back intended drive only in the led role, else 0; not the led level
      rd0_q    <= {pad_in[7:6], led_role & port_zero_data[PIN_LED], pad_in[4:0]};
      rd1_q    <= {6'h00, pad_in[9:8]};
    end
  end

  assign pad_out                = out_q;
  assign pad_oe                 = oe_q;
  assign pin5_pulldown_off      = pd_off_q;
  assign led_current_sel        = lvl_q;
  assign led_actual_drive_state = drive_q;
  assign crystal_oscillator_in  = xo_q;
  assign reference_clock_in     = ref_q;
  assign debug_link_clock       = dclk_q;
  assign debug_link_data_in     = ddat_q;
  assign port_zero_read         = rd0_q;
  assign port_one_read          = rd1_q;

  // checks
  property p_xtal_input_only;
    @(posedge clk) disable iff (sys_rst) 1'b1 |=> !pad_oe[PIN_XTAL];
  endproperty
  a_xtal_input_only: assert property (p_xtal_input_only) else $error("pin0 driven");

  property p_debug_data;
    @(posedge clk) disable iff (sys_rst)
      debug_transaction |=> pad_out[PIN_DBG_DATA] == $past(debug_link_data_out);
  endproperty
  a_debug_data: assert property (p_debug_data) else $error("pin4 not debug data");

  property p_clk6;
    @(posedge clk) disable iff (sys_rst) clk6 |=> pad_oe[PIN_CLK_ALT];
  endproperty
  a_clk6: assert property (p_clk6) else $error("pin6 clock not driven");

  property p_led_lit;
    @(posedge clk) disable iff (sys_rst)
      led_on |=> pin5_pulldown_off && !pad_oe[PIN_LED] && led_actual_drive_state;
  endproperty
  a_led_lit: assert property (p_led_lit) else $error("led on but pulldown active");

  property p_debug_no_led;
    @(posedge clk) disable iff (sys_rst) debug_session |=> led_current_sel == LED_LEVEL_OFF;
  endproperty
  a_debug_no_led: assert property (p_debug_no_led) else $error("led during debug");

  property p_ref_route;
    @(posedge clk) disable iff (sys_rst)
      !reference_clock_enable |=> !reference_clock_in;
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("ref clock leaked");

  property p_prog_first;
    @(posedge clk) disable iff (sys_rst) programming_active |=> !crystal_oscillator_in;
  endproperty
  a_prog_first: assert property (p_prog_first) else $error("crystal over programming");

  property p_pin9;
    @(posedge clk) disable iff (sys_rst)
      port_one_drive_config[1] |=> pad_oe[9] && pad_out[9] == $past(port_one_data[1]);
  endproperty
  a_pin9: assert property (p_pin9) else $error("pin9 push-pull wrong");
endmodule // gsrm_mux

// *** tb/gsrm_far_side.sv ***
// far side model: pads with pull-ups, push buttons and the debug host
`timescale 1ns/100ps
module gsrm_far_side (
  // pad side
  input  wire logic [9:0] pad_out,
  input  wire logic [9:0] pad_oe,
  input  wire logic [9:0] button,
  // host side
  input  wire logic       host_connect,
  input  wire logic       host_keep_led,
  output logic [9:0]      pad_in,
  output logic            debug_session,
  output logic            debug_led_disable
);
  // a released pad goes to its pull-up unless a button shorts it low
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~button);
  // a connected host holds a session open
  assign debug_session = host_connect;
  // led disable raised while connected unless host_keep_led, released again on disconnect
  assign debug_led_disable = host_connect & ~host_keep_led;
endmodule // gsrm_far_side

// *** tb/gsrm_mux_tb.sv ***
// self-checking bench for the pin role mux
`timescale 1ns/100ps
module gsrm_mux_tb;
  import gsrm_pkg::*;
  logic clk = 0, sys_rst = 1, pa = 0, xe = 0, re = 0, ce = 0, uc = 0, dt = 0, dout = 0, doe = 0;
  logic [7:0] p0 = 8'hff, c0 = 8'h00, p1 = 8'h03, c1 = 8'h00, r0, r1;
  logic [1:0] sel = 2'h0, lvl = 2'h0, lsel;
  logic [9:0] pin, po, poe, btn = 10'h000;
  logic       hc = 0, hk = 0, ds, dld, pdo, xin, rin, dclk, din, led;
  int         num_errors = 0, samples_checked = 0;
  // 200 MHz core clock
  always #2.5 clk = ~clk;
  gsrm_mux i_dut (.clk(clk), .sys_rst(sys_rst), .port_zero_data(p0),
    .port_zero_drive_config(c0), .port_one_data(p1), .port_one_drive_config(c1),
    .programming_active(pa), .crystal_input_enable(xe), .reference_clock_enable(re),
    .clock_output_enable(ce), .clock_output_pin_select(sel), .led_current_level(lvl),
    .user_clock(uc), .debug_transaction(dt), .debug_session(ds), .debug_led_disable(dld),
    .debug_link_data_out(dout), .debug_link_data_oe(doe), .pad_in(pin), .pad_out(po),
    .pad_oe(poe), .pin5_pulldown_off(pdo), .led_current_sel(lsel), .crystal_oscillator_in(xin),
    .reference_clock_in(rin), .debug_link_clock(dclk), .debug_link_data_in(din),
    .port_zero_read(r0), .port_one_read(r1), .led_actual_drive_state(led));
  gsrm_far_side i_far (.pad_out(po), .pad_oe(poe), .button(btn), .host_connect(hc),
    .host_keep_led(hk), .pad_in(pin), .debug_session(ds), .debug_led_disable(dld));
  // registered outputs, then the pad loop back into the read path
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // pin 0 is never driven; programming beats the crystal input
  task automatic t_pin0;
    p0[0] = 0; c0[0] = 1; xe = 1; btn[0] = 1; settle;
    chk(poe[0], 0);
    chk(xin, 0);
    btn[0] = 0; settle;
    chk(xin, 1);
    pa = 1; settle;
    chk(xin, 0);
    pa = 0; xe = 0; p0[0] = 1; c0[0] = 0;
  endtask
  // plain port pins over every data and drive config pair
  task automatic t_ports;
    for (int k = 0; k < 4; k++) begin
      p0[7] = k[0]; p0[1] = k[0]; c0[7] = k[1]; c0[1] = k[1];
      p1[1:0] = {2{k[0]}}; c1[1:0] = {2{k[1]}}; settle;
      chk({poe[9:7], poe[1]}, {4{k[1] | ~k[0]}});
      chk({pin[9:7], pin[1]}, {4{k[0]}});
      chk({r1, r0[7], r0[1]}, {6'h00, {4{k[0]}}});
    end
  endtask
  // reference clock takes pin 3 away from the port
  task automatic t_pin3;
    c0[3] = 1; p0[3] = 0; re = 1; btn[3] = 1; settle;
    chk({poe[3], rin}, 0);
    btn[3] = 0; settle;
    chk(rin, 1);
    re = 0; settle;
    chk({poe[3], pin[3]}, 2'h2);
  endtask
  // clock out on pins 4 and 6, debug data beats it on pin 4
  task automatic t_pin4;
    c0[4] = 1; p0[4] = 0; c0[6] = 1; p0[6] = 0; ce = 1; sel = 2'h3; uc = 1; settle;
    chk({po[6], poe[6], po[4], poe[4]}, 4'hf);
    uc = 0; settle;
    chk({po[6], po[4]}, 0);
    dt = 1; dout = 1; doe = 1; settle;
    chk({po[6], po[4], poe[4]}, 3'h3);
    doe = 0; btn[4] = 1; settle;
    chk({poe[4], din}, 0);
    btn[4] = 0; settle;
    chk({poe[4], din}, 2'h1);
    dt = 0; sel = 2'h2; settle;
    chk({poe[6], poe[4], pin[4]}, 3'h6);
    ce = 0;
  endtask
  // led driver on pin 5 against the debug clock role
  task automatic t_led;
    c0[5] = 1; p0[5] = 1; btn[5] = 1; settle;
    chk({poe[5], po[5], dclk}, 3'h0);
    btn[5] = 0; settle;
    chk(dclk, 1);
    // pad released high, yet the led role keeps the debug clock quiet
    for (int lv = 1; lv < 4; lv++) begin
      lvl = lv[1:0]; settle;
      chk(lsel, lv[1:0]);
      chk({poe[5], pdo, led, r0[5], dclk}, 5'h0e);
    end
    p0[5] = 0; settle;
    chk({poe[5], po[5], pdo, led, r0[5]}, 5'h10);
    // the debug session keeps the led dark while the host connects, even with bit 5 set
    hc = 1; settle;
    chk({poe[5], led, lsel}, 4'h8);
    p0[5] = 1; settle;
    chk({poe[5], led, pdo, dclk}, 4'h1);
    hc = 0; settle;
    chk({poe[5], led}, 2'h1);
    lvl = 0; p0[5] = 1; btn[5] = 0;
  endtask
  // watchdog far beyond the roughly 90 cycles the tests need
  initial begin
    #20000;
    num_errors++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk(poe, 10'h000);
    chk(po, 10'h3ff);
    sys_rst = 0;
    t_pin0;
    t_ports;
    t_pin3;
    t_pin4;
    t_led;
    test_done;
  end
endmodule // gsrm_mux_tb
